/* File: verilog/rss_sequencer.sv */
`timescale 1ns/1ps
// Behaviour
// - low-power brownout holds reset, sets brownout pattern
// - low-power monitor enabled only by config
// - brownout request is OR of both monitors
// - pin enabled by programming or pin enable
// - enabled low pin holds reset, weak pull-up
// - glitches on pin filtered out
// - pin never driven low by resets
// - disabled pin is input, software pull-up
// - watchdog timeout resets, clears watchdog flags
// - reset instruction clears its flag only
// - enabled stack faults reset and set flag
// - programming exit acts as power-on reset
// - power-up timer enabled by low config bit
// - run after timers and pin release
// - timers ignore pin; start ten cycles later
// - power-on loads flag defaults
// - flags per cause; vector zero on resets
// - watchdog sleep wake continues, clears both flags
// - interrupt wake sets expiry, clears sleep
// - interrupt wake with enable jumps to 0004h
// - pin reset awake clears pin flag only
// - pin reset in sleep also sets expiry
module rss_sequencer
	import rss_pkg::*;
#(
	parameter int unsigned PWRT_COUNT     = PWRT_CYCLES,
	parameter int unsigned OST_COUNT      = OST_CYCLES_DEFAULT,
	parameter int unsigned FILTER_SAMPLES = MASTER_CLEAR_PIN_FILTER_DEFAULT
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        power_on_i,
	input  wire logic        prog_exit_i,
	input  wire logic        lp_brownout_cfg_i,
	input  wire logic        lp_brownout_low_i,
	input  wire logic        main_brownout_i,
	input  wire logic        master_clear_pin_enable_i,
	input  wire logic        low_voltage_programming_enable_i,
	input  wire logic        powerup_timer_enable_n_i,
	input  wire logic        osc_start_needed_i,
	input  wire logic        stack_fault_reset_enable_i,
	input  wire logic        master_clear_pin_i,
	input  wire logic        sw_pullup_i,
	input  wire logic        watchdog_timeout_i,
	input  wire logic        reset_instr_i,
	input  wire logic        stack_overflow_i,
	input  wire logic        stack_underflow_i,
	input  wire logic        sleeping_i,
	input  wire logic        interrupt_wake_i,
	input  wire logic        global_interrupt_enable_i,
	input  wire logic [7:0]  power_control_register_wr_data_i,
	input  wire logic        power_control_register_wr_i,
	input  wire logic [15:0] pc_next_i,
	output logic             cpu_reset_o,
	output logic             wake_o,
	output logic [15:0]      pc_load_o,
	output logic             pc_load_valid_o,
	output logic             pin_pullup_en_o,
	output logic             pin_out_o,
	output logic             pin_oe_o,
	output logic             pin_gpio_o,
	output logic             brownout_req_o,
	output logic [7:0]       power_control_register_o,
	output logic             watchdog_expiry_flag_o,
	output logic             sleep_entered_flag_o
);
	rss_timer_if pwrt_if ();
	rss_timer_if ost_if ();
	rss_state_e  state_q;
	logic [7:0]  power_control_register_q;
	logic [1:0]  stat_q;
	logic [3:0]  rel_cnt_q;
	logic        pin_level;
	logic        pin_en;
	logic        pin_hold;
	logic        bor_req;
	logic        por_ev;
	logic        stk_ovf_ev;
	logic        stk_unf_ev;
	logic        wdt_rst_ev;
	logic        wdt_wake_ev;
	logic        pin_ev;
	logic        any_sync_rst;
	logic        timers_done;
	logic        pwrt_skip;
	logic        ost_skip;
	logic        pin_hold_d1_q;
	logic [15:0] pc_q;
	logic        pc_v_q;
	logic        wake_q;

	assign bor_req = (lp_brownout_cfg_i & lp_brownout_low_i) | main_brownout_i;
	assign pin_en  = master_clear_pin_enable_i | low_voltage_programming_enable_i;
	assign pin_hold = pin_en & ~pin_level;
	assign por_ev  = power_on_i | prog_exit_i;
	assign stk_ovf_ev = stack_fault_reset_enable_i & stack_overflow_i;
	assign stk_unf_ev = stack_fault_reset_enable_i & stack_underflow_i;
	assign wdt_rst_ev = watchdog_timeout_i & ~sleeping_i;
	assign wdt_wake_ev = watchdog_timeout_i & sleeping_i & (state_q == RSS_RUN);
	// only a pin reset out of run or sleep counts; a pin held low through start-up leaves the flag alone
	assign pin_ev = pin_hold & ~pin_hold_d1_q & (state_q == RSS_RUN);
	assign any_sync_rst = wdt_rst_ev | reset_instr_i | stk_ovf_ev | stk_unf_ev;

	rss_pin_filter #(.SAMPLES(FILTER_SAMPLES)) u_filter (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (master_clear_pin_i),
		.level_o (pin_level)
	);
	rss_timer #(.CYCLES(PWRT_COUNT)) u_pwrt (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.t       (pwrt_if.tmr)
	);
	rss_timer #(.CYCLES(OST_COUNT)) u_ost (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.t       (ost_if.tmr)
	);

	// timers start on power/brownout release, whatever the pin does
	assign pwrt_if.start = por_ev | bor_req;
	assign ost_if.start  = por_ev | bor_req;
	assign pwrt_skip   = powerup_timer_enable_n_i;
	assign ost_skip    = ~osc_start_needed_i;
	assign timers_done = (pwrt_skip | pwrt_if.done) & (ost_skip | ost_if.done);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_hold_d1_q <= 1'b0;
		end else begin
			pin_hold_d1_q <= pin_hold;
		end
	end

	// sequencing state
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q   <= RSS_POWER_OFF;
			rel_cnt_q <= '0;
		end else if (por_ev | bor_req) begin
			state_q   <= RSS_WAIT_TIMERS;
			rel_cnt_q <= '0;
		end else begin
			case (state_q)
				RSS_POWER_OFF: begin
					state_q <= RSS_POWER_OFF;
				end
				RSS_WAIT_TIMERS: begin
					if (timers_done) begin
						state_q <= RSS_WAIT_PIN;
					end
				end
				RSS_WAIT_PIN: begin
					rel_cnt_q <= '0;
					if (!pin_hold) begin
						state_q <= RSS_RELEASE;
					end
				end
				RSS_RELEASE: begin
					if (pin_hold) begin
						state_q <= RSS_WAIT_PIN;
					end else if (rel_cnt_q == 4'(RELEASE_OSC_CYCLES - 1)) begin
						state_q <= RSS_RUN;
					end else begin
						rel_cnt_q <= rel_cnt_q + 1'b1;
					end
				end
				RSS_RUN: begin
					if (pin_hold) begin
						state_q <= RSS_WAIT_PIN;
					end else if (any_sync_rst) begin
						state_q <= RSS_RELEASE;
						rel_cnt_q <= '0;
					end
				end
				default: begin
					state_q <= RSS_POWER_OFF;
				end
			endcase
		end
	end

	// power control flags; hardware events win over software writes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_control_register_q <= POWER_CONTROL_REGISTER_POR_VALUE;
		end else if (por_ev) begin
			power_control_register_q <= POWER_CONTROL_REGISTER_POR_VALUE;
		end else if (bor_req) begin
			power_control_register_q[POWER_CONTROL_REGISTER_STK_OVF_BIT]   <= 1'b0;
			power_control_register_q[POWER_CONTROL_REGISTER_STK_UNF_BIT]   <= 1'b0;
			power_control_register_q[POWER_CONTROL_REGISTER_PIN_RST_BIT]   <= 1'b1;
			power_control_register_q[POWER_CONTROL_REGISTER_INSTR_RST_BIT] <= 1'b1;
			power_control_register_q[POWER_CONTROL_REGISTER_BOR_BIT]       <= 1'b0;
		end else begin
			if (power_control_register_wr_i) begin
				power_control_register_q <= power_control_register_wr_data_i & 8'hdf;
			end
			if (stk_ovf_ev) begin
				power_control_register_q[POWER_CONTROL_REGISTER_STK_OVF_BIT] <= 1'b1;
			end
			if (stk_unf_ev) begin
				power_control_register_q[POWER_CONTROL_REGISTER_STK_UNF_BIT] <= 1'b1;
			end
			if (wdt_rst_ev) begin
				power_control_register_q[POWER_CONTROL_REGISTER_WDT_RST_BIT] <= 1'b0;
			end
			if (pin_ev) begin
				power_control_register_q[POWER_CONTROL_REGISTER_PIN_RST_BIT] <= 1'b0;
			end
			if (reset_instr_i) begin
				power_control_register_q[POWER_CONTROL_REGISTER_INSTR_RST_BIT] <= 1'b0;
			end
		end
	end

	// status flags: expiry, sleep
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_q <= STAT_POR_VALUE;
		end else if (por_ev | bor_req) begin
			stat_q <= STAT_POR_VALUE;
		end else if (wdt_rst_ev) begin
			stat_q[STAT_WDT_EXPIRY_BIT] <= 1'b0;
		end else if (wdt_wake_ev) begin
			stat_q <= 2'h0;
		end else if (pin_ev & sleeping_i) begin
			stat_q <= 2'h2;
		end else if (interrupt_wake_i & sleeping_i & (state_q == RSS_RUN)) begin
			stat_q <= 2'h2;
		end
	end

	// program counter loads: vector zero for resets, next or interrupt vector for wakes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_q   <= RESET_VECTOR;
			pc_v_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			wake_q <= 1'b0;
			pc_v_q <= 1'b0;
			if (state_q == RSS_RELEASE && rel_cnt_q == 4'(RELEASE_OSC_CYCLES - 1) && !pin_hold) begin
				pc_q   <= RESET_VECTOR;
				pc_v_q <= 1'b1;
			end else if (state_q == RSS_RUN && sleeping_i && (interrupt_wake_i | watchdog_timeout_i)) begin
				wake_q <= 1'b1;
				pc_v_q <= 1'b1;
				if (interrupt_wake_i & global_interrupt_enable_i) begin
					pc_q <= INTERRUPT_VECTOR;
				end else begin
					pc_q <= pc_next_i;
				end
			end
		end
	end

	assign cpu_reset_o              = (state_q != RSS_RUN);
	assign wake_o                   = wake_q;
	assign pc_load_o                = pc_q;
	assign pc_load_valid_o          = pc_v_q;
	assign pin_out_o                = 1'b0;
	assign pin_oe_o                 = 1'b0;
	assign pin_pullup_en_o          = pin_en ? 1'b1 : sw_pullup_i;
	assign pin_gpio_o               = pin_en ? 1'b0 : master_clear_pin_i;
	assign brownout_req_o           = bor_req;
	assign power_control_register_o = power_control_register_q;
	assign watchdog_expiry_flag_o   = stat_q[STAT_WDT_EXPIRY_BIT];
	assign sleep_entered_flag_o     = stat_q[STAT_SLEEP_BIT];

	// cycles spent in the release countdown, counted apart from rel_cnt_q so the check below is independent
	logic [3:0] rel_len_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rel_len_q <= '0;
		end else if (state_q == RSS_RELEASE) begin
			if (rel_len_q != 4'hf) begin
				rel_len_q <= rel_len_q + 1'b1;
			end
		end else begin
			rel_len_q <= '0;
		end
	end

	brownout_holds_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		bor_req |=> cpu_reset_o && !power_control_register_o[POWER_CONTROL_REGISTER_BOR_BIT])
		else $error("brownout did not hold reset");
	lp_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!lp_brownout_cfg_i && !main_brownout_i) |-> !brownout_req_o)
		else $error("disabled monitor requested reset");
	pin_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(pin_hold && state_q == RSS_RUN) |=> cpu_reset_o)
		else $error("low pin did not hold reset");
	pin_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!pin_oe_o)
		else $error("pin driven");
	gpio_pull_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!pin_en |-> pin_pullup_en_o == sw_pullup_i)
		else $error("pull-up not under software");
	release_ten_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$fell(cpu_reset_o) |-> rel_len_q == 4'(RELEASE_OSC_CYCLES))
		else $error("released earlier than ten cycles");
	instr_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(reset_instr_i && !por_ev && !bor_req) |=> !power_control_register_o[POWER_CONTROL_REGISTER_INSTR_RST_BIT])
		else $error("instruction flag not cleared");
	wdt_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wdt_wake_ev && !por_ev && !bor_req) |=> !watchdog_expiry_flag_o && !sleep_entered_flag_o && wake_o)
		else $error("watchdog wake flags wrong");
	por_flags_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		por_ev |=> power_control_register_o == POWER_CONTROL_REGISTER_POR_VALUE && watchdog_expiry_flag_o)
		else $error("power-on flags wrong");
endmodule

/* File: verilog/rss_pkg.sv */
package rss_pkg;
	// status flags: watchdog expiry, sleep entered
	localparam int unsigned STAT_WDT_EXPIRY_BIT   = 1;
	localparam int unsigned STAT_SLEEP_BIT        = 0;
	// power control register bit positions
	localparam int unsigned POWER_CONTROL_REGISTER_STK_OVF_BIT      = 7;
	localparam int unsigned POWER_CONTROL_REGISTER_STK_UNF_BIT      = 6;
	localparam int unsigned POWER_CONTROL_REGISTER_WDT_RST_BIT      = 4;
	localparam int unsigned POWER_CONTROL_REGISTER_PIN_RST_BIT      = 3;
	localparam int unsigned POWER_CONTROL_REGISTER_INSTR_RST_BIT    = 2;
	localparam int unsigned POWER_CONTROL_REGISTER_POR_BIT          = 1;
	localparam int unsigned POWER_CONTROL_REGISTER_BOR_BIT          = 0;
	localparam logic [7:0]  POWER_CONTROL_REGISTER_POR_VALUE        = 8'h1c;
	localparam logic [1:0]  STAT_POR_VALUE        = 2'h3;
	localparam logic [15:0] RESET_VECTOR          = 16'h0000;
	localparam logic [15:0] INTERRUPT_VECTOR      = 16'h0004;
	localparam int unsigned CLK_PERIOD_PS         = 8000;
	localparam int unsigned PWRT_TIME_US          = 64000;
	localparam int unsigned PWRT_CYCLES           = (PWRT_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int unsigned OST_CYCLES_DEFAULT    = 1024;
	localparam int unsigned RELEASE_OSC_CYCLES    = 10;
	localparam int unsigned MASTER_CLEAR_PIN_FILTER_DEFAULT   = 2;
	typedef enum {RSS_POWER_OFF, RSS_WAIT_TIMERS, RSS_WAIT_PIN, RSS_RELEASE, RSS_RUN} rss_state_e;
endpackage

/* File: verilog/rss_timer_if.sv */
`timescale 1ns/1ps
interface rss_timer_if;
	logic start;
	logic done;
	modport ctrl (output start, input done);
	modport tmr  (input start, output done);
endinterface

/* File: verilog/rss_timer.sv */
`timescale 1ns/1ps
module rss_timer
	import rss_pkg::*;
#(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	rss_timer_if.tmr  t
);
	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
	logic [W-1:0] cnt_q;
	logic         done_q;

	// restart on each start pulse; done holds until the next start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (t.start) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (!done_q) begin
			if (cnt_q == W'(CYCLES - 1)) begin
				done_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
	assign t.done = done_q;
endmodule

/* File: verilog/rss_pin_filter.sv */
`timescale 1ns/1ps
module rss_pin_filter #(
	parameter int unsigned SAMPLES = 2
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic pin_i,
	output logic      level_o
);
	localparam int unsigned W = $clog2(SAMPLES + 1);
	logic [W-1:0] cnt_q;
	logic         level_q;

	// pin idles high; a level must persist SAMPLES cycles to change the output
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q   <= '0;
			level_q <= 1'b1;
		end else if (pin_i == level_q) begin
			cnt_q <= '0;
		end else if (cnt_q == W'(SAMPLES - 1)) begin
			cnt_q   <= '0;
			level_q <= pin_i;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign level_o = level_q;
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	import rss_pkg::*;
	localparam int unsigned PW = 20;
	localparam int unsigned OS = 8;
	localparam int R = RELEASE_OSC_CYCLES;
	localparam logic [7:0] E_PON = 8'h80, E_PEX = 8'h40, E_WDT = 8'h20, E_RIN = 8'h10;
	localparam logic [7:0] E_SOV = 8'h08, E_SUN = 8'h04, E_IWK = 8'h02, E_PWR = 8'h01;
	logic        clk;
	logic        rst_b;
	logic        pon, pex, lpc, lpl, mbo, mce, low_voltage_programming_enable, pwn, osn, sfe, pin, swp;
	logic        wdt, rin, sov, sun, slp, iwk, global_interrupt_enable, pwr;
	logic [7:0]  pwd;
	logic [15:0] pcn;
	logic        cpu_rst, wk, plv, pup, pout, poe, pgp, breq, wexp, sflg;
	logic [15:0] pl;
	logic [7:0]  power_control_register;
	int          mismatches;
	int          total_checks;

	rss_sequencer #(.PWRT_COUNT(PW), .OST_COUNT(OS), .FILTER_SAMPLES(MASTER_CLEAR_PIN_FILTER_DEFAULT)) dut (
		.clk_i(clk), .rst_b_i(rst_b), .power_on_i(pon), .prog_exit_i(pex),
		.lp_brownout_cfg_i(lpc), .lp_brownout_low_i(lpl), .main_brownout_i(mbo),
		.master_clear_pin_enable_i(mce), .low_voltage_programming_enable_i(low_voltage_programming_enable),
		.powerup_timer_enable_n_i(pwn), .osc_start_needed_i(osn), .stack_fault_reset_enable_i(sfe),
		.master_clear_pin_i(pin), .sw_pullup_i(swp), .watchdog_timeout_i(wdt), .reset_instr_i(rin),
		.stack_overflow_i(sov), .stack_underflow_i(sun), .sleeping_i(slp), .interrupt_wake_i(iwk),
		.global_interrupt_enable_i(global_interrupt_enable), .power_control_register_wr_data_i(pwd), .power_control_register_wr_i(pwr), .pc_next_i(pcn),
		.cpu_reset_o(cpu_rst), .wake_o(wk), .pc_load_o(pl), .pc_load_valid_o(plv),
		.pin_pullup_en_o(pup), .pin_out_o(pout), .pin_oe_o(poe), .pin_gpio_o(pgp),
		.brownout_req_o(breq), .power_control_register_o(power_control_register),
		.watchdog_expiry_flag_o(wexp), .sleep_entered_flag_o(sflg)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one-cycle event pulse; every strobe is rewritten here, so callers let an edge pass before the next pulse
	task automatic ev(input logic [7:0] m);
		{pon, pex, wdt, rin, sov, sun, iwk, pwr} = m;
		tick(1);
		{pon, pex, wdt, rin, sov, sun, iwk, pwr} = 8'h00;
	endtask

	task automatic wait_run(input int lo, input int hi);
		int n;
		n = 0;
		while (cpu_rst !== 1'b0 && n < 2000) begin
			tick(1);
			n++;
		end
		chk8("run_delay_in_range", 8'h01, {7'h0, (n >= lo && n <= hi)});
		chk8("pc_load_valid", 8'h01, {7'h0, plv});
		chk16("pc_load_reset", RESET_VECTOR, pl);
	endtask

	task automatic wait_wake(input logic [15:0] e);
		int n;
		n = 0;
		while (wk !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		chk8("wake_pulse", 8'h01, {7'h0, wk});
		chk16("wake_pc", e, pl);
		tick(1);
		chk8("wake_no_reset", 8'h00, {7'h0, cpu_rst});
	endtask

	task automatic t_por;
		chk8("power_control_register_in_reset", POWER_CONTROL_REGISTER_POR_VALUE, power_control_register);
		chk8("status_in_reset", {6'h0, STAT_POR_VALUE}, {6'h0, wexp, sflg});
		rst_b = 1'b1;
		tick(2);
		chk8("held_before_power", 8'h01, {7'h0, cpu_rst});
		pin = 1'b0;
		ev(E_PON);
		tick(PW + OS + 12);
		chk8("held_by_pin", 8'h01, {7'h0, cpu_rst});
		pin = 1'b1;
		wait_run(R, R + 6);
		chk8("power_control_register_por", 8'h1c, power_control_register & 8'hfe);
		chk8("status_por", 8'h03, {6'h0, wexp, sflg});
		chk8("pin_never_driven", 8'h00, {6'h0, poe, pout});
	endtask

	task automatic t_prog;
		pwd = 8'hff;
		ev(E_PWR);
		tick(1);
		chk8("power_control_register_write", 8'hdf, power_control_register);
		osn = 1'b0;
		ev(E_PEX);
		tick(1);
		chk8("power_control_register_prog_exit", 8'h1c, power_control_register & 8'hfe);
		wait_run(PW, PW + R + 8);
		pwn = 1'b1;
		ev(E_PON);
		wait_run(R - 1, PW - 1);
	endtask

	task automatic t_sync;
		pwd = 8'h1f;
		ev(E_PWR);
		tick(1);
		ev(E_RIN);
		tick(1);
		chk8("power_control_register_instr", 8'h1b, power_control_register);
		chk8("instr_holds", 8'h01, {7'h0, cpu_rst});
		wait_run(R - 3, R + 4);
		ev(E_WDT);
		tick(1);
		chk8("power_control_register_wdt", 8'h0b, power_control_register);
		chk8("status_wdt", 8'h01, {6'h0, wexp, sflg});
		wait_run(R - 3, R + 4);
		ev(E_SOV);
		tick(1);
		ev(E_SUN);
		tick(1);
		chk8("stack_off_flags", 8'h0b, power_control_register);
		chk8("stack_off_run", 8'h00, {7'h0, cpu_rst});
		sfe = 1'b1;
		ev(E_SOV);
		tick(1);
		chk8("power_control_register_ovf", 8'h8b, power_control_register);
		wait_run(R - 3, R + 4);
		ev(E_SUN);
		tick(1);
		chk8("power_control_register_unf", 8'hcb, power_control_register);
		wait_run(R - 3, R + 4);
	endtask

	task automatic t_pin;
		pwd = 8'hff;
		ev(E_PWR);
		pin = 1'b0;
		tick(1);
		pin = 1'b1;
		tick(6);
		chk8("glitch_no_reset", 8'h00, {7'h0, cpu_rst});
		chk8("glitch_no_flag", 8'hdf, power_control_register);
		mce = 1'b0;
		swp = 1'b1;
		pin = 1'b0;
		tick(6);
		chk8("pin_off_no_reset", 8'h00, {7'h0, cpu_rst});
		chk8("gpio_low_pullup", 8'h01, {6'h0, pgp, pup});
		pin = 1'b1;
		swp = 1'b0;
		tick(3);
		chk8("gpio_high_no_pullup", 8'h02, {6'h0, pgp, pup});
		low_voltage_programming_enable = 1'b1;
		tick(3);
		chk8("pin_on_pullup", 8'h01, {6'h0, pgp, pup});
		pin = 1'b0;
		tick(6);
		chk8("pin_holds", 8'h01, {7'h0, cpu_rst});
		chk8("power_control_register_pin", 8'hd7, power_control_register);
		chk8("status_pin", 8'h01, {6'h0, wexp, sflg});
		pin = 1'b1;
		wait_run(R - 2, R + 8);
		low_voltage_programming_enable = 1'b0;
		mce = 1'b1;
	endtask

	task automatic t_brown;
		pwd = 8'hc3;
		ev(E_PWR);
		lpl = 1'b1;
		tick(3);
		chk8("lp_off_no_req", 8'h00, {6'h0, breq, cpu_rst});
		lpc = 1'b1;
		tick(3);
		chk8("lp_req_holds", 8'h03, {6'h0, breq, cpu_rst});
		chk8("power_control_register_brownout", 8'h0e, power_control_register);
		chk8("status_brownout", 8'h03, {6'h0, wexp, sflg});
		lpl = 1'b0;
		mbo = 1'b1;
		tick(1);
		chk8("main_req", 8'h01, {7'h0, breq});
		mbo = 1'b0;
		wait_run(R - 1, R + 10);
	endtask

	task automatic t_sleep;
		slp = 1'b1;
		global_interrupt_enable = 1'b1;
		pcn = 16'h1235;
		ev(E_IWK);
		wait_wake(INTERRUPT_VECTOR);
		chk8("status_int_wake", 8'h02, {6'h0, wexp, sflg});
		global_interrupt_enable = 1'b0;
		ev(E_IWK);
		wait_wake(16'h1235);
		ev(E_WDT);
		wait_wake(16'h1235);
		chk8("status_wdt_wake", 8'h00, {6'h0, wexp, sflg});
		chk8("power_control_register_after_wakes", 8'h0e, power_control_register);
		pin = 1'b0;
		tick(6);
		chk8("status_pin_sleep", 8'h02, {6'h0, wexp, sflg});
		chk8("power_control_register_pin_sleep", 8'h06, power_control_register);
		slp = 1'b0;
		pin = 1'b1;
		wait_run(R - 2, R + 8);
	endtask

	// generous bound: the whole sequence needs well under a thousand cycles
	initial begin
		#100us;
		mismatches++;
		results();
	end

	initial begin
		mismatches = 0;
		total_checks = 0;
		rst_b = 1'b0;
		{pon, pex, lpc, lpl, mbo, low_voltage_programming_enable, sfe, swp, wdt, rin, sov, sun, slp, iwk, global_interrupt_enable, pwr} = 16'h0000;
		mce = 1'b1;
		pin = 1'b1;
		pwn = 1'b0;
		osn = 1'b1;
		pwd = 8'h00;
		pcn = 16'h0000;
		repeat (20) @(negedge clk);
		t_por();
		t_prog();
		t_sync();
		t_pin();
		t_brown();
		t_sleep();
		results();
	end
endmodule
